// ### hdl/vr_cfg_pkg.sv
package vr_cfg_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CFG3_OFFSET     = 8'h45;
    localparam logic [15:0] CFG3_RESET      = 16'h0000;
    localparam logic [15:0] CFG3_WMASK      = 16'h7fff;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_TEMP_FAULT_LATCH = 14;
    localparam int BIT_SHED_ACT_SEL     = 13;
    localparam int BIT_PHASE_SRC_SEL    = 12;
    localparam int BIT_VOUT_MIN_TOP     = 11;
    localparam int BIT_BAL_SS_RUN       = 10;
    localparam int BIT_BAL_VAR_GAIN     = 9;
    localparam int FLD_GAIN_HI          = 8;
    localparam int FLD_GAIN_LO          = 6;
    localparam int BIT_THREE_LVL_VID    = 5;
    localparam int BIT_TON_CLAMP        = 4;
    localparam int BIT_TEMP_OFS_SIGN    = 3;
    localparam int BIT_BOOT_FROM_PIN    = 2;
    localparam int FLD_TABLE_HI         = 1;
    localparam int FLD_TABLE_LO         = 0;
    // ------------------------------------------------------------
    // derived constants
    // ------------------------------------------------------------
    localparam int          NUM_PHASES     = 6;
    localparam logic [7:0]  GAIN_STEP      = 8'h20;
    localparam logic [7:0]  GAIN_BASE      = 8'h1f;
    localparam int          TON_MAX_NS     = 1120;
    localparam int          CLK_PERIOD_NS  = 25;
    localparam logic [7:0]  TON_MAX_CYC    =
        8'(TON_MAX_NS / CLK_PERIOD_NS);
    localparam logic [7:0]  VID_MAX_SEL    = 8'h24;
    localparam logic [7:0]  VID_MIN_SEL    = 8'h1f;
    localparam logic [7:0]  VID_CMD_SEL    = 8'h21;
    typedef enum logic [1:0] {
        VID_PIN_LOW, VID_PIN_HIGH, VID_PIN_HIZ
    } vid_pin_t;
endpackage

// ### hdl/phase_count_detect.sv
module phase_count_detect (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // sampling
    input  wire logic       sample,
    input  wire logic [5:0] sense_grounded,
    // result
    output logic      [2:0] count_q
);
    logic [2:0] count_d;
    logic       done_q;

    // a grounded pin stops the count, blocking every higher phase
    always_comb begin
        count_d = 3'h6;
        for (int i = 5; i >= 0; i--) begin
            if (sense_grounded[i]) begin
                count_d = 3'(i);
            end
        end
    end

    // only the first power-on sample counts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 3'h0;
            done_q  <= 1'b0;
        end else if (sample && !done_q) begin
            count_q <= count_d;
            done_q  <= 1'b1;
        end
    end
endmodule // phase_count_detect

// ### hdl/vr_function_config.sv
// Overview of operation
// - bit 14 picks latch-off (1) or hiccup (0) for a temperature fault.
// - bit 13 holds mid-state shedding until the vid pin first leaves hi-z after soft start.
// - bit 12 takes phase count from config1 or from sense pins at por.
// - a grounded sense pin disables its phase and all higher phases.
// - bit 11 is the top bit of the minimum output voltage parameter.
// - bit 10 lets the balance loop run during soft start.
// - bit 9 picks large gain when a phase strays over 50mV from phase one.
// - bits 8:6 set large gain as value times 32 plus 31.
// - bit 5 lets the vid pin pick max, min or command/boot target.
// - bit 4 clamps on-time to the programmed minimum up to 1120ns.
// - bit 3 is the sign of the temperature sense offset.
// - bit 2 picks boot voltage from command register or boot pin.
// - bits 1:0 select the pin-strapped boot table.
module vr_function_config (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // register port
    input  wire logic        WR_EN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    output logic      [15:0] RDATA,
    // controller status
    input  wire logic        SOFTSTART_DONE,
    input  wire logic        PSI_MID,
    input  wire logic        VID_PIN_HIZ,
    input  wire logic        VID_PIN_HIGH,
    input  wire logic        TEMP_FAULT,
    input  wire logic        POR_SAMPLE,
    input  wire logic [5:0]  SENSE_GROUNDED,
    input  wire logic [5:0]  BAL_ERR_OVER,
    input  wire logic [3:0]  CONFIG1_PHASES,
    input  wire logic [6:0]  MIN_ON_CYC,
    input  wire logic [7:0]  TON_CALC_CYC,
    // steering outputs
    output logic             TEMP_LATCH_OFF,
    output logic             TEMP_HICCUP,
    output logic             SHED_ENABLE,
    output logic      [3:0]  PHASE_COUNT,
    output logic             VOUT_MIN_TOP,
    output logic             BAL_HOLD,
    output logic      [7:0]  BAL_GAIN,
    output logic             BAL_USE_LARGE,
    output logic      [7:0]  VID_TARGET_SEL,
    output logic      [7:0]  TON_OUT_CYC,
    output logic             TEMP_OFS_SIGN,
    output logic             BOOT_FROM_PIN,
    output logic      [1:0]  BOOT_TABLE
);
    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    logic [15:0] cfg_q;
    logic        vid_left_hiz_q;
    logic        ss_seen_q;
    logic [2:0]  pin_count;
    logic [7:0]  gain_field;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_q <= vr_cfg_pkg::CFG3_RESET;
        end else if (WR_EN && ADDR == vr_cfg_pkg::CFG3_OFFSET) begin
            cfg_q <= WDATA & vr_cfg_pkg::CFG3_WMASK;
        end
    end

    // registered read: data answers one edge after the address
    // unmapped offsets read zero
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
        end else if (ADDR == vr_cfg_pkg::CFG3_OFFSET) begin
            RDATA <= cfg_q & vr_cfg_pkg::CFG3_WMASK;
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // temperature fault response
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            TEMP_LATCH_OFF <= 1'b0;
            TEMP_HICCUP    <= 1'b0;
        end else begin
            TEMP_LATCH_OFF <= TEMP_FAULT
                && cfg_q[vr_cfg_pkg::BIT_TEMP_FAULT_LATCH];
            TEMP_HICCUP    <= TEMP_FAULT
                && !cfg_q[vr_cfg_pkg::BIT_TEMP_FAULT_LATCH];
        end
    end

    // ------------------------------------------------------------
    // phase shedding activation
    // ------------------------------------------------------------
    // first exit from hi-z after soft start is remembered; later hi-z does not re-arm
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            vid_left_hiz_q <= 1'b0;
            ss_seen_q      <= 1'b0;
        end else begin
            if (SOFTSTART_DONE) begin
                ss_seen_q <= 1'b1;
            end
            if (ss_seen_q && !VID_PIN_HIZ) begin
                vid_left_hiz_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            SHED_ENABLE <= 1'b0;
        end else if (!PSI_MID) begin
            SHED_ENABLE <= 1'b0;
        end else if (cfg_q[vr_cfg_pkg::BIT_SHED_ACT_SEL]) begin
            SHED_ENABLE <= ss_seen_q && vid_left_hiz_q;
        end else begin
            SHED_ENABLE <= ss_seen_q;
        end
    end

    // ------------------------------------------------------------
    // phase count
    // ------------------------------------------------------------
    phase_count_detect u_detect (
        .clk            (MCLK),
        .rst_n          (RST_N),
        .sample         (POR_SAMPLE),
        .sense_grounded (SENSE_GROUNDED),
        .count_q        (pin_count)
    );

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PHASE_COUNT <= 4'h0;
        end else if (cfg_q[vr_cfg_pkg::BIT_PHASE_SRC_SEL]) begin
            PHASE_COUNT <= {1'b0, pin_count};
        end else begin
            PHASE_COUNT <= CONFIG1_PHASES;
        end
    end

    // ------------------------------------------------------------
    // current balance loop
    // ------------------------------------------------------------
    assign gain_field = {5'h00,
        cfg_q[vr_cfg_pkg::FLD_GAIN_HI:vr_cfg_pkg::FLD_GAIN_LO]};

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            BAL_HOLD      <= 1'b0;
            BAL_GAIN      <= 8'h00;
            BAL_USE_LARGE <= 1'b0;
        end else begin
            BAL_HOLD <= !SOFTSTART_DONE
                && !cfg_q[vr_cfg_pkg::BIT_BAL_SS_RUN];
            BAL_GAIN <= 8'(gain_field * vr_cfg_pkg::GAIN_STEP
                + vr_cfg_pkg::GAIN_BASE);
            // comparators outside flag the 50mV error per phase
            BAL_USE_LARGE <= cfg_q[vr_cfg_pkg::BIT_BAL_VAR_GAIN]
                && (|BAL_ERR_OVER);
        end
    end

    // ------------------------------------------------------------
    // vid target and boot
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            VID_TARGET_SEL <= vr_cfg_pkg::VID_CMD_SEL;
        end else if (!cfg_q[vr_cfg_pkg::BIT_THREE_LVL_VID]) begin
            VID_TARGET_SEL <= vr_cfg_pkg::VID_CMD_SEL;
        end else if (VID_PIN_HIZ) begin
            VID_TARGET_SEL <= vr_cfg_pkg::VID_CMD_SEL;
        end else if (VID_PIN_HIGH) begin
            VID_TARGET_SEL <= vr_cfg_pkg::VID_MAX_SEL;
        end else begin
            VID_TARGET_SEL <= vr_cfg_pkg::VID_MIN_SEL;
        end
    end

    // plain copies: the loops they steer sit outside this block
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            BOOT_FROM_PIN <= 1'b0;
            BOOT_TABLE    <= 2'h0;
            VOUT_MIN_TOP  <= 1'b0;
            TEMP_OFS_SIGN <= 1'b0;
        end else begin
            BOOT_FROM_PIN <= cfg_q[vr_cfg_pkg::BIT_BOOT_FROM_PIN];
            BOOT_TABLE    <= cfg_q[vr_cfg_pkg::FLD_TABLE_HI:
                                   vr_cfg_pkg::FLD_TABLE_LO];
            VOUT_MIN_TOP  <= cfg_q[vr_cfg_pkg::BIT_VOUT_MIN_TOP];
            TEMP_OFS_SIGN <= cfg_q[vr_cfg_pkg::BIT_TEMP_OFS_SIGN];
        end
    end

    // ------------------------------------------------------------
    // on-time clamp
    // ------------------------------------------------------------
    // unclamped path trusts the host to keep on-time in range
    // upper clamp stops a long computed on-time past 1120ns
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            TON_OUT_CYC <= 8'h00;
        end else if (!cfg_q[vr_cfg_pkg::BIT_TON_CLAMP]) begin
            TON_OUT_CYC <= TON_CALC_CYC;
        end else if (TON_CALC_CYC < {1'b0, MIN_ON_CYC}) begin
            TON_OUT_CYC <= {1'b0, MIN_ON_CYC};
        end else if (TON_CALC_CYC > vr_cfg_pkg::TON_MAX_CYC) begin
            TON_OUT_CYC <= vr_cfg_pkg::TON_MAX_CYC;
        end else begin
            TON_OUT_CYC <= TON_CALC_CYC;
        end
    end
endmodule // vr_function_config

// ### tb/vr_cfg_monitor.sv
module vr_cfg_monitor (
    // clock and reset
    input wire logic        MCLK,
    input wire logic        RST_N,
    // control inputs
    input wire logic        SOFTSTART_DONE,
    input wire logic        PSI_MID,
    input wire logic        VID_PIN_HIZ,
    input wire logic        TEMP_FAULT,
    input wire logic [7:0]  ADDR,
    input wire logic [7:0]  TON_CALC_CYC,
    input wire logic [5:0]  BAL_ERR_OVER,
    input wire logic [6:0]  MIN_ON_CYC,
    // watched outputs
    input wire logic        TEMP_LATCH_OFF,
    input wire logic        TEMP_HICCUP,
    input wire logic        SHED_ENABLE,
    input wire logic        BAL_HOLD,
    input wire logic        BAL_USE_LARGE,
    input wire logic [7:0]  BAL_GAIN,
    input wire logic [7:0]  VID_TARGET_SEL,
    input wire logic [7:0]  TON_OUT_CYC,
    input wire logic [15:0] RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // ----------------------------------------
    // output relations, one cycle of latency
    // ----------------------------------------
    a_temp_resp: assert property ($past(RST_N) |->
        ((TEMP_LATCH_OFF | TEMP_HICCUP) == $past(TEMP_FAULT))
        && !(TEMP_LATCH_OFF && TEMP_HICCUP)) else $error("temp response");
    a_shed_mid: assert property (SHED_ENABLE |-> $past(PSI_MID))
        else $error("shedding outside mid state");
    a_hold_ss: assert property ($past(RST_N) && $past(SOFTSTART_DONE)
        |-> !BAL_HOLD) else $error("balance held after soft start");
    a_large_cause: assert property (BAL_USE_LARGE |->
        $past(BAL_ERR_OVER) != 6'h00) else $error("large gain no cause");
    a_gain_base: assert property ($past(RST_N) |->
        BAL_GAIN[4:0] == 5'h1f) else $error("gain offset wrong");
    a_vid_hiz: assert property ($past(RST_N) && $past(VID_PIN_HIZ)
        |-> VID_TARGET_SEL == 8'h21) else $error("hi-z vid code");
    a_ton_clamp: assert property ($past(RST_N) &&
        TON_OUT_CYC != $past(TON_CALC_CYC) |-> TON_OUT_CYC <= 8'h2c
        && TON_OUT_CYC >= {1'b0, $past(MIN_ON_CYC)}) else $error("ton");
    a_rd_unmapped: assert property ($past(RST_N) && $past(ADDR) != 8'h45
        |-> RDATA == 16'h0000) else $error("unmapped read not zero");
    a_reserved_zero: assert property (!RDATA[15])
        else $error("reserved bit set");
    c_latch: cover property (TEMP_LATCH_OFF);
    c_large: cover property (BAL_USE_LARGE);
    c_shed: cover property (SHED_ENABLE);
endmodule // vr_cfg_monitor

bind vr_function_config vr_cfg_monitor vr_cfg_monitor_i (.MCLK, .RST_N,
    .SOFTSTART_DONE, .PSI_MID, .VID_PIN_HIZ, .TEMP_FAULT, .ADDR,
    .TON_CALC_CYC, .BAL_ERR_OVER, .MIN_ON_CYC, .TEMP_LATCH_OFF,
    .TEMP_HICCUP, .SHED_ENABLE, .BAL_HOLD, .BAL_USE_LARGE, .BAL_GAIN,
    .VID_TARGET_SEL, .TON_OUT_CYC, .RDATA);

// ### tb/cfg_host.sv
module cfg_host (
    // bus
    input  wire logic        MCLK,
    input  wire logic [15:0] RDATA,
    output logic             WR_EN,
    output logic      [7:0]  ADDR,
    output logic      [15:0] WDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        WR_EN = 1'h0;
        ADDR = 8'h00;
        WDATA = 16'h0000;
    end
    // data inverted once released so a stale word never looks valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge MCLK);
        WR_EN = 1'h1;
        ADDR = a;
        WDATA = d;
        @(negedge MCLK);
        WR_EN = 1'h0;
        WDATA = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge MCLK);
        ADDR = a;
        @(negedge MCLK);
        d = RDATA;
    endtask
endmodule // cfg_host

// ### tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 1'h0, RST_N = 1'h0, SOFTSTART_DONE = 1'h0, PSI_MID = 1'h0;
    logic VID_PIN_HIZ = 1'h1, VID_PIN_HIGH = 1'h0, TEMP_FAULT = 1'h0;
    logic POR_SAMPLE = 1'h0, WR_EN, TEMP_LATCH_OFF, TEMP_HICCUP, SHED_ENABLE;
    logic VOUT_MIN_TOP, BAL_HOLD, BAL_USE_LARGE, TEMP_OFS_SIGN, BOOT_FROM_PIN;
    logic [5:0] SENSE_GROUNDED = 6'h00, BAL_ERR_OVER = 6'h00;
    logic [3:0] CONFIG1_PHASES = 4'h0, PHASE_COUNT;
    logic [6:0] MIN_ON_CYC = 7'h00;
    logic [7:0] TON_CALC_CYC = 8'h14, ADDR, BAL_GAIN, VID_TARGET_SEL;
    logic [7:0] TON_OUT_CYC;
    logic [15:0] WDATA, RDATA;
    logic [1:0] BOOT_TABLE;
    int miscompares = 0;
    int n_tests = 0;
    logic [1:0] vpin[3] = '{2'h1, 2'h0, 2'h2};
    logic [7:0] vexp[3] = '{8'h24, 8'h1f, 8'h21};
    logic [7:0] tcalc[3] = '{8'h05, 8'h3c, 8'h14};
    logic [7:0] texp[3] = '{8'h0a, 8'h2c, 8'h14};
    always #12.5 MCLK = ~MCLK;
    vr_function_config vr_function_config_i (.MCLK, .RST_N, .WR_EN, .ADDR,
        .WDATA, .RDATA, .SOFTSTART_DONE, .PSI_MID, .VID_PIN_HIZ,
        .VID_PIN_HIGH, .TEMP_FAULT, .POR_SAMPLE, .SENSE_GROUNDED,
        .BAL_ERR_OVER, .CONFIG1_PHASES, .MIN_ON_CYC, .TON_CALC_CYC,
        .TEMP_LATCH_OFF, .TEMP_HICCUP, .SHED_ENABLE, .PHASE_COUNT,
        .VOUT_MIN_TOP, .BAL_HOLD, .BAL_GAIN, .BAL_USE_LARGE,
        .VID_TARGET_SEL, .TON_OUT_CYC, .TEMP_OFS_SIGN, .BOOT_FROM_PIN,
        .BOOT_TABLE);
    cfg_host cfg_host_i (.MCLK, .RDATA, .WR_EN, .ADDR, .WDATA);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [15:0] s, e);
        n_tests++;
        if (s !== e) begin
            $display("BAD %s exp %h seen %h", n, e, s);
            miscompares++;
        end
    endtask
    // one extra edge: outputs trail the config by a cycle
    task automatic wc(input logic [15:0] d);
        cfg_host_i.wr(8'h45, d);
        @(negedge MCLK);
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        cfg_host_i.rd(a, d);
        chk("rdata", d, e);
    endtask
    task automatic end_sim;
        $display("checks %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge MCLK);
        miscompares++;
        end_sim;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge MCLK);
        RST_N = 1'h1;
        rc(8'h45, 16'h0000);
        wc(16'hffff);
        rc(8'h45, 16'h7fff);
        chk("bits", 16'({VOUT_MIN_TOP, TEMP_OFS_SIGN, BOOT_FROM_PIN,
            BOOT_TABLE}), 16'h001f);
        cfg_host_i.wr(8'h44, 16'h0000);
        rc(8'h44, 16'h0000);
        rc(8'h45, 16'h7fff);
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            wc({7'h00, 3'(i), 3'h0, 3'(i)});
            chk("gain", 16'(BAL_GAIN), 16'(i * 32 + 31));
            // bits 11 and 3 are written zero here
            chk("boot", 16'({VOUT_MIN_TOP, TEMP_OFS_SIGN, BOOT_FROM_PIN,
                BOOT_TABLE}), 16'(i));
        end
        TEMP_FAULT = 1'h1;
        for (int m = 0; m < 2; m++) begin
            wc(16'(m) << 14);
            chk("temp", 16'({TEMP_LATCH_OFF, TEMP_HICCUP}),
                16'(m + 1));
        end
        TEMP_FAULT = 1'h0;
        BAL_ERR_OVER = 6'h04;
        for (int m = 0; m < 4; m++) begin
            wc(16'(m) << 9);
            chk("bal", 16'({BAL_HOLD, BAL_USE_LARGE}),
                16'(m ^ 2));
        end
        $display("field test done");
        wc(16'h0020);
        for (int k = 0; k < 3; k++) begin
            {VID_PIN_HIZ, VID_PIN_HIGH} = vpin[k];
            @(negedge MCLK);
            chk("vid", 16'(VID_TARGET_SEL), 16'(vexp[k]));
        end
        MIN_ON_CYC = 7'h0a;
        wc(16'h0010);
        for (int k = 0; k < 3; k++) begin
            TON_CALC_CYC = tcalc[k];
            @(negedge MCLK);
            chk("ton", 16'(TON_OUT_CYC), 16'(texp[k]));
        end
        // with the clamp off, an on-time below the minimum must pass through unclamped
        TON_CALC_CYC = 8'h05;
        wc(16'h0000);
        chk("ton", 16'(TON_OUT_CYC), 16'h0005);
        $display("vid and ton test done");
        CONFIG1_PHASES = 4'h5;
        @(negedge MCLK);
        chk("phase", 16'(PHASE_COUNT), 16'h0005);
        wc(16'h1000);
        chk("phase", 16'(PHASE_COUNT), 16'h0000);
        // board grounds phases four to six, so three remain
        SENSE_GROUNDED = 6'h38;
        for (int p = 0; p < 2; p++) begin
            POR_SAMPLE = 1'h1;
            @(negedge MCLK);
            POR_SAMPLE = 1'h0;
            SENSE_GROUNDED = 6'h02;
            repeat (2) @(negedge MCLK);
            chk("phase", 16'(PHASE_COUNT), 16'h0003);
        end
        wc(16'h2000);
        PSI_MID = 1'h1;
        SOFTSTART_DONE = 1'h1;
        repeat (5) @(negedge MCLK);
        chk("shed", 16'(SHED_ENABLE), 16'h0000);
        VID_PIN_HIZ = 1'h0;
        repeat (5) @(negedge MCLK);
        chk("shed", 16'(SHED_ENABLE), 16'h0001);
        PSI_MID = 1'h0;
        repeat (2) @(negedge MCLK);
        chk("shed", 16'(SHED_ENABLE), 16'h0000);
        $display("phase and shed test done");
        // second reset: register clears, shedding re-arms in mode 0
        PSI_MID = 1'h1;
        SOFTSTART_DONE = 1'h0;
        VID_PIN_HIZ = 1'h1;
        RST_N = 1'h0;
        repeat (2) @(negedge MCLK);
        RST_N = 1'h1;
        rc(8'h45, 16'h0000);
        chk("shed", 16'(SHED_ENABLE), 16'h0000);
        SOFTSTART_DONE = 1'h1;
        repeat (3) @(negedge MCLK);
        chk("shed", 16'(SHED_ENABLE), 16'h0001);
        $display("reset and shed mode test done");
        end_sim;
    end
endmodule // testbench
